// ==== logic/eic_defines.svh ====
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH

// Register indices (printed offsets; byte address is four times these)
`define EIC_IDX_PCHG 8'hae
`define EIC_IDX_XFLG 8'haf
`define EIC_IDX_XEN 8'hb5
`define EIC_IDX_EDG1 8'hb6
`define EIC_IDX_EDG2 8'hb7
`define EIC_IDX_SENSE 8'hb8

// Field positions
`define EIC_PC_P9_EN 7
`define EIC_PC_P6_EN 5
`define EIC_PC_P5_EN 4
`define EIC_PC_P9_FLG 3
`define EIC_PC_P6_FLG 1
`define EIC_PC_P5_FLG 0
`define EIC_XEN_D 1
`define EIC_XEN_C 0
`define EIC_E1_GSEL_HI 7
`define EIC_E1_GSEL_LO 6
`define EIC_E1_B_POL 2
`define EIC_E1_A_POL 0
`define EIC_E2_D_POL 1
`define EIC_E2_C_POL 0
`define EIC_SENSE_A 0
`define EIC_SENSE_B 1

// Writable masks
`define EIC_PCHG_WMASK 8'hbb
`define EIC_XFLG_WMASK 8'h03
`define EIC_XEN_WMASK 8'h03
`define EIC_EDG1_WMASK 8'hc5
`define EIC_EDG2_WMASK 8'h03
`define EIC_SENSE_WMASK 8'h03
`define EIC_RESET_VAL 8'h00
`define EIC_PIN_IDLE 4'hf

// Deglitch times in ns
`define EIC_CLK_PERIOD_NS 8
`define EIC_GLITCH0_NS 50
`define EIC_GLITCH1_NS 200
`define EIC_GLITCH2_NS 400
`define EIC_GLITCH0_CYC ((`EIC_GLITCH0_NS + `EIC_CLK_PERIOD_NS - 1) / `EIC_CLK_PERIOD_NS)
`define EIC_GLITCH1_CYC ((`EIC_GLITCH1_NS + `EIC_CLK_PERIOD_NS - 1) / `EIC_CLK_PERIOD_NS)
`define EIC_GLITCH2_CYC ((`EIC_GLITCH2_NS + `EIC_CLK_PERIOD_NS - 1) / `EIC_CLK_PERIOD_NS)

`define EIC_RESP_OKAY 2'b00
`define EIC_RESP_SLVERR 2'b10

`endif

// ==== logic/eic_pkg.sv ====
package eic_pkg;
  localparam int EIC_NPIN = 4;
  localparam int EIC_CW = 6;

  typedef struct packed {
    logic [7:0] pchg;
    logic [7:0] xflg;
    logic [7:0] xen;
    logic [7:0] edg1;
    logic [7:0] edg2;
    logic [7:0] sense;
  } eic_regs_t;

  typedef struct packed {
    logic aw_done;
    logic [7:0] aw_idx;
    logic aw_bad;
    logic w_done;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eic_bus_t;

  typedef struct packed {
    eic_regs_t regs;
    eic_bus_t bus;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_f;
    logic [3:0][5:0] cnt;
    logic [23:0] port_s1;
    logic [23:0] port_s2;
    logic [23:0] port_q;
    logic [3:0] irq;
    logic pchg_irq;
  } eic_state_t;
endpackage

// ==== logic/eic_top.sv ====
`timescale 1ns/1ps
`include "eic_defines.svh"

// Functional notes
// - Pin D events only when enabled
// - Pin C events only when enabled
// - Two-bit field selects deglitch time or bypass
// - Pin B polarity selects falling or rising
// - Pin A polarity selects falling or rising
// - Pin D polarity selects falling or rising
// - Pin C polarity selects falling or rising
// - Pin D flag sticky until written zero
// - Pin C flag sticky until written zero
// - Port 9 monitored only when enabled
// - Port 6 monitored only when enabled
// - Port 5 monitored only when enabled
// - Port 9 change sets sticky flag
// - Port 6 change sets sticky flag
// - Port 5 change sets sticky flag
// - Any pin change on an enabled port sets flag, raises request
// - Edge control bits 5:3 read zero
// - Pins A/B low-level or edge per type
// - Detection independent of processor clock
module eic_top
  import eic_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [3:0] ext_irq_pin_i,
  input wire logic [PORT_W-1:0] port_five_i,
  input wire logic [PORT_W-1:0] port_six_i,
  input wire logic [PORT_W-1:0] port_nine_i,
  // Requests: [0]=A [1]=B [2]=C [3]=D
  output logic [3:0] ext_irq_o,
  output logic pin_change_irq_o
);

  if (PORT_W < 1 || PORT_W > 8) begin : g_bad_port_w
    $error("PORT_W must be 1..8");
  end

  localparam int CW = EIC_CW;
  // Pins start at their idle level so no false edge follows reset
  localparam eic_state_t ST_RST = '{pin_s1: `EIC_PIN_IDLE,
    pin_s2: `EIC_PIN_IDLE, pin_f: `EIC_PIN_IDLE, default: '0};

  eic_state_t st_reg, st_next;

  function automatic logic [7:0] wmerge(input logic [7:0] old,
      input logic [7:0] wd, input logic [7:0] m);
    wmerge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic [7:0] idx_of(input logic [11:0] a);
    idx_of = a[9:2];
  endfunction

  function automatic logic idx_ok(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    idx_ok = (a[11:10] == 2'b00) && a[1:0] == 2'b00 &&
      (i == `EIC_IDX_PCHG || i == `EIC_IDX_XFLG || i == `EIC_IDX_XEN ||
       i == `EIC_IDX_EDG1 || i == `EIC_IDX_EDG2 || i == `EIC_IDX_SENSE);
  endfunction

  logic [1:0] gsel;
  logic [CW-1:0] glen;
  logic [3:0] pol;
  logic [3:0] rise, fall, edge_hit, pin_evt;
  logic [3:0] pin_en;
  logic [2:0] port_en;
  logic [2:0] port_evt;
  logic do_write;
  logic [7:0] wbyte;

  assign gsel = {st_reg.regs.edg1[`EIC_E1_GSEL_HI],
                 st_reg.regs.edg1[`EIC_E1_GSEL_LO]};
  assign pol = {st_reg.regs.edg2[`EIC_E2_D_POL],
                st_reg.regs.edg2[`EIC_E2_C_POL],
                st_reg.regs.edg1[`EIC_E1_B_POL],
                st_reg.regs.edg1[`EIC_E1_A_POL]};
  assign pin_en = {st_reg.regs.xen[`EIC_XEN_D],
                   st_reg.regs.xen[`EIC_XEN_C], 2'b11};
  assign port_en = {st_reg.regs.pchg[`EIC_PC_P9_EN],
                    st_reg.regs.pchg[`EIC_PC_P6_EN],
                    st_reg.regs.pchg[`EIC_PC_P5_EN]};

  always_comb begin
    case (gsel)
      2'b00: glen = CW'(`EIC_GLITCH0_CYC);
      2'b01: glen = CW'(`EIC_GLITCH1_CYC);
      2'b10: glen = CW'(`EIC_GLITCH2_CYC);
      default: glen = '0;
    endcase
  end

  always_comb begin
    logic [23:0] chg;
    logic [7:0] p5, p6, p9;
    st_next = st_reg;
    chg = '0;
    p5 = '0;
    p6 = '0;
    p9 = '0;
    // Two-flop synchronisers; filters read only the second stage
    st_next.pin_s1 = ext_irq_pin_i;
    st_next.pin_s2 = st_reg.pin_s1;
    p5[PORT_W-1:0] = port_five_i;
    p6[PORT_W-1:0] = port_six_i;
    p9[PORT_W-1:0] = port_nine_i;
    st_next.port_s1 = {p9, p6, p5};
    st_next.port_s2 = st_reg.port_s1;
    st_next.port_q = st_reg.port_s2;
    // Deglitch: new level must hold glen cycles, or pass at once on bypass
    for (int i = 0; i < 4; i++) begin
      if (st_reg.pin_s2[i] == st_reg.pin_f[i]) begin
        st_next.cnt[i] = '0;
      end else if (gsel == 2'b11 || st_reg.cnt[i] + 1'b1 >= glen) begin
        st_next.pin_f[i] = st_reg.pin_s2[i];
        st_next.cnt[i] = '0;
      end else begin
        st_next.cnt[i] = CW'(st_reg.cnt[i] + 1'b1);
      end
    end
    rise = (st_reg.pin_f ^ st_next.pin_f) & st_next.pin_f;
    fall = (st_reg.pin_f ^ st_next.pin_f) & ~st_next.pin_f;
    edge_hit = (pol & rise) | (~pol & fall);
    pin_evt = edge_hit & pin_en;
    chg = st_reg.port_s2 ^ st_reg.port_q;
    port_evt = {|chg[23:16], |chg[15:8], |chg[7:0]} & port_en;

    // AXI4-Lite
    if (st_reg.bus.bvalid && s_axi_bready) st_next.bus.bvalid = 1'b0;
    if (st_reg.bus.rvalid && s_axi_rready) st_next.bus.rvalid = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.bus.aw_done = 1'b1;
      st_next.bus.aw_idx = idx_of(s_axi_awaddr);
      st_next.bus.aw_bad = !idx_ok(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.bus.w_done = 1'b1;
      st_next.bus.w_data = s_axi_wdata;
      st_next.bus.w_strb = s_axi_wstrb;
    end
    do_write = st_reg.bus.aw_done && st_reg.bus.w_done &&
               !st_reg.bus.bvalid;
    wbyte = st_reg.bus.w_data[7:0];
    if (do_write) begin
      st_next.bus.aw_done = 1'b0;
      st_next.bus.w_done = 1'b0;
      st_next.bus.bvalid = 1'b1;
      st_next.bus.bresp = st_reg.bus.aw_bad ? `EIC_RESP_SLVERR :
                                              `EIC_RESP_OKAY;
      if (!st_reg.bus.aw_bad && st_reg.bus.w_strb[0]) begin
        if (st_reg.bus.aw_idx == `EIC_IDX_PCHG) begin
          st_next.regs.pchg = wmerge(st_reg.regs.pchg, wbyte,
                                     `EIC_PCHG_WMASK);
        end else if (st_reg.bus.aw_idx == `EIC_IDX_XFLG) begin
          st_next.regs.xflg = wmerge(st_reg.regs.xflg, wbyte,
                                     `EIC_XFLG_WMASK);
        end else if (st_reg.bus.aw_idx == `EIC_IDX_XEN) begin
          st_next.regs.xen = wmerge(st_reg.regs.xen, wbyte,
                                    `EIC_XEN_WMASK);
        end else if (st_reg.bus.aw_idx == `EIC_IDX_EDG1) begin
          st_next.regs.edg1 = wmerge(st_reg.regs.edg1, wbyte,
                                     `EIC_EDG1_WMASK);
        end else if (st_reg.bus.aw_idx == `EIC_IDX_EDG2) begin
          st_next.regs.edg2 = wmerge(st_reg.regs.edg2, wbyte,
                                     `EIC_EDG2_WMASK);
        end else if (st_reg.bus.aw_idx == `EIC_IDX_SENSE) begin
          st_next.regs.sense = wmerge(st_reg.regs.sense, wbyte,
                                      `EIC_SENSE_WMASK);
        end
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.bus.rvalid = 1'b1;
      st_next.bus.rresp = `EIC_RESP_OKAY;
      st_next.bus.rdata = '0;
      if (!idx_ok(s_axi_araddr)) begin
        st_next.bus.rresp = `EIC_RESP_SLVERR;
      end else if (idx_of(s_axi_araddr) == `EIC_IDX_PCHG) begin
        st_next.bus.rdata[7:0] = st_reg.regs.pchg;
      end else if (idx_of(s_axi_araddr) == `EIC_IDX_XFLG) begin
        st_next.bus.rdata[7:0] = st_reg.regs.xflg;
      end else if (idx_of(s_axi_araddr) == `EIC_IDX_XEN) begin
        st_next.bus.rdata[7:0] = st_reg.regs.xen;
      end else if (idx_of(s_axi_araddr) == `EIC_IDX_EDG1) begin
        st_next.bus.rdata[7:0] = st_reg.regs.edg1;
      end else if (idx_of(s_axi_araddr) == `EIC_IDX_EDG2) begin
        st_next.bus.rdata[7:0] = st_reg.regs.edg2;
      end else begin
        st_next.bus.rdata[7:0] = st_reg.regs.sense;
      end
    end

    // Hardware sets after software writes, so a set wins
    if (pin_evt[3]) st_next.regs.xflg[`EIC_XEN_D] = 1'b1;
    if (pin_evt[2]) st_next.regs.xflg[`EIC_XEN_C] = 1'b1;
    if (port_evt[2]) st_next.regs.pchg[`EIC_PC_P9_FLG] = 1'b1;
    if (port_evt[1]) st_next.regs.pchg[`EIC_PC_P6_FLG] = 1'b1;
    if (port_evt[0]) st_next.regs.pchg[`EIC_PC_P5_FLG] = 1'b1;

    // Pins A/B: low level when type 0, edge pulse when type 1
    for (int i = 0; i < 2; i++) begin
      if (st_reg.regs.sense[i]) begin
        st_next.irq[i] = edge_hit[i];
      end else begin
        st_next.irq[i] = !st_next.pin_f[i];
      end
    end
    st_next.irq[2] = st_next.regs.xflg[`EIC_XEN_C] &&
                     st_next.regs.xen[`EIC_XEN_C];
    st_next.irq[3] = st_next.regs.xflg[`EIC_XEN_D] &&
                     st_next.regs.xen[`EIC_XEN_D];
    st_next.pchg_irq =
      (st_next.regs.pchg[`EIC_PC_P9_FLG] &&
       st_next.regs.pchg[`EIC_PC_P9_EN]) ||
      (st_next.regs.pchg[`EIC_PC_P6_FLG] &&
       st_next.regs.pchg[`EIC_PC_P6_EN]) ||
      (st_next.regs.pchg[`EIC_PC_P5_FLG] &&
       st_next.regs.pchg[`EIC_PC_P5_EN]);
  end

  // Runs on the always-on system clock, not the processor clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.bus.aw_done;
  assign s_axi_wready = !st_reg.bus.w_done;
  assign s_axi_bvalid = st_reg.bus.bvalid;
  assign s_axi_bresp = st_reg.bus.bresp;
  assign s_axi_arready = !st_reg.bus.rvalid;
  assign s_axi_rvalid = st_reg.bus.rvalid;
  assign s_axi_rdata = st_reg.bus.rdata;
  assign s_axi_rresp = st_reg.bus.rresp;
  assign ext_irq_o = st_reg.irq;
  assign pin_change_irq_o = st_reg.pchg_irq;

  property p_pin_d_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      !st_reg.regs.xen[`EIC_XEN_D] && !st_reg.regs.xflg[`EIC_XEN_D] &&
      !do_write |=> !st_reg.regs.xflg[`EIC_XEN_D];
  endproperty
  a_pin_d_off: assert property (p_pin_d_off)
    else $error("pin D flag set while disabled");

  property p_pin_c_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      !st_reg.regs.xen[`EIC_XEN_C] |-> !ext_irq_o[2];
  endproperty
  a_pin_c_off: assert property (p_pin_c_off)
    else $error("pin C request while disabled");

  property p_bypass;
    @(posedge clk_i) disable iff (!rst_b_i)
      gsel == 2'b11 && $stable(gsel) && st_reg.pin_s2 != st_reg.pin_f
      |=> st_reg.pin_f == $past(st_reg.pin_s2);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not pass level at once");

  property p_glitch;
    @(posedge clk_i) disable iff (!rst_b_i)
      gsel == 2'b00 && $fell(st_reg.pin_s2[3]) && st_reg.pin_f[3]
      |=> st_reg.pin_f[3] [*5];
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("filter passed level too early");

  property p_flag_d;
    @(posedge clk_i) disable iff (!rst_b_i)
      pin_evt[3] |=> st_reg.regs.xflg[`EIC_XEN_D];
  endproperty
  a_flag_d: assert property (p_flag_d)
    else $error("pin D flag not set");

  property p_flag_c;
    @(posedge clk_i) disable iff (!rst_b_i)
      st_reg.regs.xflg[`EIC_XEN_C] && !do_write
      |=> st_reg.regs.xflg[`EIC_XEN_C];
  endproperty
  a_flag_c: assert property (p_flag_c)
    else $error("pin C flag dropped without write");

  property p_port5;
    @(posedge clk_i) disable iff (!rst_b_i)
      port_evt[0] |=> st_reg.regs.pchg[`EIC_PC_P5_FLG] &&
      (pin_change_irq_o || !st_reg.regs.pchg[`EIC_PC_P5_EN]);
  endproperty
  a_port5: assert property (p_port5)
    else $error("port 5 change not flagged");

  property p_port9_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      !st_reg.regs.pchg[`EIC_PC_P9_EN] &&
      !st_reg.regs.pchg[`EIC_PC_P9_FLG] && !do_write
      |=> !st_reg.regs.pchg[`EIC_PC_P9_FLG];
  endproperty
  a_port9_off: assert property (p_port9_off)
    else $error("port 9 event while disabled");

  property p_rsvd;
    @(posedge clk_i) disable iff (!rst_b_i)
      st_reg.regs.edg1[5:3] == 3'b000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved edge bits set");

  property p_level;
    @(posedge clk_i) disable iff (!rst_b_i)
      !st_reg.regs.sense[0] && !st_next.pin_f[0] |=> ext_irq_o[0];
  endproperty
  a_level: assert property (p_level)
    else $error("low level on pin A not requested");

  property p_pulse_a;
    @(posedge clk_i) disable iff (!rst_b_i)
      st_reg.regs.sense[`EIC_SENSE_A] && !st_reg.regs.edg1[`EIC_E1_A_POL] &&
      st_reg.pin_f[0] && !st_next.pin_f[0] |=> ext_irq_o[0];
  endproperty
  a_pulse_a: assert property (p_pulse_a)
    else $error("pin A falling edge not requested");

  property p_pulse_b;
    @(posedge clk_i) disable iff (!rst_b_i)
      st_reg.regs.sense[`EIC_SENSE_B] && !st_reg.regs.edg1[`EIC_E1_B_POL] &&
      !st_reg.pin_f[1] && st_next.pin_f[1] |=> !ext_irq_o[1];
  endproperty
  a_pulse_b: assert property (p_pulse_b)
    else $error("pin B request on unselected edge");

  property p_edge_c;
    @(posedge clk_i) disable iff (!rst_b_i)
      st_reg.regs.edg2[`EIC_E2_C_POL] && st_reg.pin_f[2] &&
      !st_next.pin_f[2] && !st_reg.regs.xflg[`EIC_XEN_C] && !do_write
      |=> !st_reg.regs.xflg[`EIC_XEN_C];
  endproperty
  a_edge_c: assert property (p_edge_c)
    else $error("pin C flag set on unselected edge");

  property p_flag_p9;
    @(posedge clk_i) disable iff (!rst_b_i)
      port_evt[2] |=> st_reg.regs.pchg[`EIC_PC_P9_FLG];
  endproperty
  a_flag_p9: assert property (p_flag_p9)
    else $error("port 9 change not flagged");

  property p_irq_d;
    @(posedge clk_i) disable iff (!rst_b_i)
      ext_irq_o[3] ==
      (st_reg.regs.xflg[`EIC_XEN_D] && st_reg.regs.xen[`EIC_XEN_D]);
  endproperty
  a_irq_d: assert property (p_irq_d)
    else $error("pin D request differs from flag and enable");

endmodule // eic_top

// ==== tb/eic_pin_src.sv ====
`timescale 1ns/1ps
module eic_pin_src (
  // Clock
  input wire logic clk_i,
  // Pin and port levels
  output logic [3:0] pin_o,
  output logic [7:0] p5_o,
  output logic [7:0] p6_o,
  output logic [7:0] p9_o
);
  // Pins idle high so level-type requests stay quiet
  initial begin
    pin_o = 4'hf;
    p5_o = 8'h00;
    p6_o = 8'h00;
    p9_o = 8'h00;
  end

  task automatic hold(input int k, input logic v, input int n);
    @(posedge clk_i);
    pin_o[k] <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic flip(input int p, input int b);
    @(posedge clk_i);
    case (p)
      0: p5_o[b] <= ~p5_o[b];
      1: p6_o[b] <= ~p6_o[b];
      default: p9_o[b] <= ~p9_o[b];
    endcase
  endtask
endmodule // eic_pin_src

// ==== tb/eic_top_tb_top.sv ====
`timescale 1ns/1ps
`include "eic_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module eic_top_tb_top;
  import eic_pkg::*;
  localparam logic [1:0] OK = `EIC_RESP_OKAY;
  localparam logic [1:0] ERR = `EIC_RESP_SLVERR;
  logic clk_i;
  logic rst_b_i;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [3:0] pin;
  logic [7:0] p5;
  logic [7:0] p6;
  logic [7:0] p9;
  logic [3:0] irq;
  logic pirq;
  logic [4:0] iv;
  logic [7:0] m;
  int error_cnt;
  int n_tests;
  int na;
  int nb;
  int k;
  int q;
  int a0;
  int b0;
  logic [7:0] ix[6] = '{`EIC_IDX_PCHG, `EIC_IDX_XFLG, `EIC_IDX_XEN,
    `EIC_IDX_EDG1, `EIC_IDX_EDG2, `EIC_IDX_SENSE};
  logic [7:0] mk[6] = '{`EIC_PCHG_WMASK, `EIC_XFLG_WMASK, `EIC_XEN_WMASK,
    `EIC_EDG1_WMASK, `EIC_EDG2_WMASK, `EIC_SENSE_WMASK};
  int g[3] = '{`EIC_GLITCH0_CYC, `EIC_GLITCH1_CYC, `EIC_GLITCH2_CYC};
  int eb[3] = '{`EIC_PC_P5_EN, `EIC_PC_P6_EN, `EIC_PC_P9_EN};
  int fb[3] = '{`EIC_PC_P5_FLG, `EIC_PC_P6_FLG, `EIC_PC_P9_FLG};

  assign iv = {pirq, irq};

  eic_top #(.PORT_W(8)) DUT (.clk_i, .rst_b_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_irq_pin_i(pin), .port_five_i(p5), .port_six_i(p6),
    .port_nine_i(p9), .ext_irq_o(irq), .pin_change_irq_o(pirq));

  eic_pin_src src (.clk_i, .pin_o(pin), .p5_o(p5), .p6_o(p6), .p9_o(p9));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Edge-type pulses on pins A and B
  always @(negedge clk_i) begin
    if (irq[0] === 1'b1) na++;
    if (irq[1] === 1'b1) nb++;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run();
  endtask

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic a;
    logic w;
    logic b;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_awaddr <= ba(i);
    s_axi_wdata <= {24'h0000_00, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (!b && n < 200) begin
      @(negedge clk_i);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!b) timeout();
    `CHK(r, er)
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e,
                    input logic [1:0] er);
    int n;
    logic a;
    logic v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_araddr <= ba(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    v = 1'b0;
    while (!v && n < 200) begin
      @(negedge clk_i);
      a = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (a) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!v) timeout();
    `CHK(d, {24'h0000_00, e})
    `CHK(r, er)
  endtask

  // Waits a bounded time for a request line to reach a level
  task automatic wirq(input int j, input logic e, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (iv[j] !== e && n < lim);
    `CHK(iv[j], e)
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    timeout();
  end

  initial begin
    rst_b_i = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (80) @(posedge clk_i);
    for (k = 0; k < 6; k++) begin
      rd(ix[k], 8'h00, OK);
      wr(ix[k], 8'hff, OK);
      rd(ix[k], mk[k], OK);
      wr(ix[k], 8'h00, OK);
    end
    wr(8'h10, 8'hff, ERR);
    rd(8'h10, 8'h00, ERR);
    wr(`EIC_IDX_EDG1, 8'hc0, OK);
    for (k = 2; k < 4; k++) begin
      m = 8'h01 << (k - 2);
      wr(`EIC_IDX_XEN, 8'h00, OK);
      wr(`EIC_IDX_EDG2, 8'h00, OK);
      src.hold(k, 1'b0, 10);
      src.hold(k, 1'b1, 10);
      rd(`EIC_IDX_XFLG, 8'h00, OK);
      wr(`EIC_IDX_XEN, m, OK);
      src.hold(k, 1'b0, 2);
      wirq(k, 1'b1, 30);
      rd(`EIC_IDX_XFLG, m, OK);
      src.hold(k, 1'b1, 10);
      rd(`EIC_IDX_XFLG, m, OK);
      wr(`EIC_IDX_XFLG, 8'h00, OK);
      rd(`EIC_IDX_XFLG, 8'h00, OK);
      wirq(k, 1'b0, 5);
      wr(`EIC_IDX_EDG2, m, OK);
      src.hold(k, 1'b0, 10);
      rd(`EIC_IDX_XFLG, 8'h00, OK);
      src.hold(k, 1'b1, 2);
      wirq(k, 1'b1, 30);
      rd(`EIC_IDX_XFLG, m, OK);
      wr(`EIC_IDX_XFLG, 8'h00, OK);
    end
    wr(`EIC_IDX_EDG2, 8'h00, OK);
    for (k = 0; k < 3; k++) begin
      wr(`EIC_IDX_EDG1, 8'(k << 6), OK);
      src.hold(3, 1'b0, g[k] / 2);
      src.hold(3, 1'b1, g[k] + 20);
      rd(`EIC_IDX_XFLG, 8'h00, OK);
      src.hold(3, 1'b0, g[k] + 8);
      wirq(3, 1'b1, 40);
      src.hold(3, 1'b1, g[k] + 20);
      wr(`EIC_IDX_XFLG, 8'h00, OK);
    end
    wr(`EIC_IDX_EDG1, 8'hc0, OK);
    src.hold(3, 1'b0, 0);
    src.hold(3, 1'b1, 20);
    rd(`EIC_IDX_XFLG, 8'h02, OK);
    wr(`EIC_IDX_XFLG, 8'h00, OK);
    for (k = 0; k < 2; k++) begin
      src.hold(k, 1'b0, 2);
      wirq(k, 1'b1, 30);
      src.hold(k, 1'b1, 2);
      wirq(k, 1'b0, 30);
    end
    wr(`EIC_IDX_SENSE, 8'h03, OK);
    for (q = 0; q < 2; q++) begin
      wr(`EIC_IDX_EDG1, q ? 8'hc4 : 8'hc1, OK);
      a0 = na;
      b0 = nb;
      src.hold(0, 1'b0, 10);
      `CHK(na - a0, q)
      src.hold(0, 1'b1, 10);
      `CHK(na - a0, 1)
      src.hold(1, 1'b0, 10);
      `CHK(nb - b0, 1 - q)
      src.hold(1, 1'b1, 10);
      `CHK(nb - b0, 1)
    end
    for (k = 0; k < 3; k++) begin
      m = 8'h01 << eb[k];
      wr(`EIC_IDX_PCHG, 8'h00, OK);
      src.flip(k, 3);
      repeat (10) @(posedge clk_i);
      rd(`EIC_IDX_PCHG, 8'h00, OK);
      wr(`EIC_IDX_PCHG, m, OK);
      src.flip(k, 5);
      wirq(4, 1'b1, 20);
      rd(`EIC_IDX_PCHG, m | (8'h01 << fb[k]), OK);
      wr(`EIC_IDX_PCHG, m, OK);
      rd(`EIC_IDX_PCHG, m, OK);
      wirq(4, 1'b0, 5);
    end
    complete_run();
  end
endmodule // eic_top_tb_top
